// File: pkg/uep_pkg.sv
// Purpose: Shared constants for the endpoint 0 and IN endpoint control block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Reply codes are what the block hands the USB engine for each IN token

package uep_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 18;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'hde07;
  localparam logic [15:0] IDX_SELECT = 16'hde0e;
  localparam logic [15:0] IDX_CSR = 16'hde11;
  localparam logic [15:0] IDX_IN_TYPE = 16'hde12;

  // ----------------------------------------------------------------
  // Endpoint 0 control/status fields
  // ----------------------------------------------------------------
  localparam int CS0_CLR_PREMATURE = 7;
  localparam int CS0_CLR_RX = 6;
  localparam int CS0_STALL_REQ = 5;
  localparam int CS0_PREMATURE = 4;
  localparam int CS0_DATA_END = 3;
  localparam int CS0_STALL_SENT = 2;
  localparam int CS0_TX_READY = 1;
  localparam int CS0_RX_READY = 0;

  // ----------------------------------------------------------------
  // IN endpoint control/status fields
  // ----------------------------------------------------------------
  localparam int IN_TOGGLE_RESET = 6;
  localparam int IN_STALL_SENT = 5;
  localparam int IN_STALL_REQ = 4;
  localparam int IN_FLUSH = 3;
  localparam int IN_UNDERRUN = 2;
  localparam int IN_OCCUPIED = 1;
  localparam int IN_TX_READY = 0;
  localparam int TYPE_ISO = 6;

  // ----------------------------------------------------------------
  // Reset values, sizes and codes
  // ----------------------------------------------------------------
  localparam int NUM_IN_EP = 5;
  localparam logic [5:0] IRQ_ENABLE_RESET = 6'h3f;
  localparam logic [3:0] INDEX_RESET = 4'h0;
  localparam logic [3:0] INDEX_MAX = 4'h5;
  localparam logic [1:0] FIFO_SLOTS = 2'h2;
  localparam logic [1:0] REPLY_DATA = 2'h0;
  localparam logic [1:0] REPLY_NAK = 2'h1;
  localparam logic [1:0] REPLY_STALL = 2'h2;
  localparam logic [1:0] REPLY_ZLP = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: core/uep_in_ep.sv
// Purpose: Control/status state of one IN endpoint
// Assumes: Engine loads at most two packets; events are one-cycle pulses
// Notes: Reply and status are combinational; the top registers them

`timescale 1ns/1ps

module uep_in_ep (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Firmware side
  input wire logic csr_wr,
  input wire logic [7:0] wdata,
  input wire logic iso,
  // Engine side
  input wire logic token,
  input wire logic sent,
  input wire logic load,
  // Results
  output logic [7:0] status,
  output logic [1:0] reply,
  output logic toggle,
  output logic irq_event,
  output logic flush_pulse
);
  logic stall_req, stall_sent, underrun, tx_ready;
  logic [1:0] occ;
  logic stall_ev, flush_wr, dec;

  // Event decode; stall has no effect on an isochronous endpoint
  assign stall_ev = token && stall_req && !iso;
  assign flush_wr = csr_wr && wdata[uep_pkg::IN_FLUSH];
  assign dec = (sent || flush_wr) && (occ != 2'h0);
  assign irq_event = sent || stall_ev;
  assign flush_pulse = flush_wr || stall_ev;

  // Reply chosen from state before this token's effects
  always_comb begin
    if (stall_ev) begin
      reply = uep_pkg::REPLY_STALL;
    end else if (tx_ready) begin
      reply = uep_pkg::REPLY_DATA;
    end else if (iso) begin
      reply = uep_pkg::REPLY_ZLP;
    end else begin
      reply = uep_pkg::REPLY_NAK;
    end
  end

  // Status view; self-clearing bits read zero
  assign status = {2'b00, stall_sent, stall_req, 1'b0, underrun, occ != 2'h0, tx_ready};

  // Stall request and stall-sent; hardware set wins over firmware clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_req <= 1'b0;
      stall_sent <= 1'b0;
    end else begin
      if (csr_wr) begin
        stall_req <= wdata[uep_pkg::IN_STALL_REQ];
      end
      if (stall_ev) begin
        stall_sent <= 1'b1;
      end else if (csr_wr) begin
        stall_sent <= stall_sent & wdata[uep_pkg::IN_STALL_SENT];
      end
    end
  end

  // Underrun on every unstalled token that finds no packet ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underrun <= 1'b0;
    end else if (token && !tx_ready && !stall_ev) begin
      underrun <= 1'b1;
    end else if (csr_wr) begin
      underrun <= underrun & wdata[uep_pkg::IN_UNDERRUN];
    end
  end

  // Packet ready: firmware sets, sent/flush/stall clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ready <= 1'b0;
    end else if (stall_ev || flush_wr || sent) begin
      tx_ready <= 1'b0;
    end else if (csr_wr) begin
      tx_ready <= wdata[uep_pkg::IN_TX_READY];
    end
  end

  // Occupancy; one flush write drops only one packet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      occ <= 2'h0;
    end else if (stall_ev) begin
      occ <= 2'h0;
    end else if (load && !dec && occ != uep_pkg::FIFO_SLOTS) begin
      occ <= occ + 2'h1;
    end else if (dec && !load) begin
      occ <= occ - 2'h1;
    end
  end

  // Data toggle; the reset request beats a flip in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle <= 1'b0;
    end else if (csr_wr && wdata[uep_pkg::IN_TOGGLE_RESET]) begin
      toggle <= 1'b0;
    end else if (sent) begin
      toggle <= ~toggle;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TOGGLE_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    csr_wr && wdata[uep_pkg::IN_TOGGLE_RESET] |=> !toggle && !status[6])
    else $error("toggle not reset");
  AST_STALL_FLUSH: assert property (@(posedge aclk) disable iff (!aresetn)
    stall_ev |=> stall_sent && occ == 2'h0 && !tx_ready)
    else $error("stall did not flush");
  AST_ISO_NO_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
    iso |-> reply != uep_pkg::REPLY_STALL)
    else $error("isochronous endpoint stalled");
  AST_UNDERRUN: assert property (@(posedge aclk) disable iff (!aresetn)
    token && !tx_ready && !stall_ev |=> underrun)
    else $error("underrun not flagged");
  AST_FLUSH_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
    flush_wr && !load && !sent && !token && occ == 2'h2 |=> occ == 2'h1 && !tx_ready)
    else $error("flush removed wrong count");
  AST_SENT_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    sent |=> !tx_ready)
    else $error("ready survived send");
  COV_UNDERRUN: cover property (@(posedge aclk) disable iff (!aresetn) token && !tx_ready);
endmodule // uep_in_ep

// File: core/uep_ctrl.sv
// Purpose: Endpoint 0 and IN endpoint 1-5 control/status with AXI4-Lite access
// Assumes: Engine events arrive on aclk as one-cycle pulses
// Notes: One shared control/status word, steered by the endpoint select index
// Operation
// - Shared status address shows endpoint 0 view at index 0, IN view at indices 1-5.
// - Writing clear-premature bit clears premature-end flag; clear bit reads zero.
// - Received packet sets rx-ready with interrupt; clear bit drops it.
// - Endpoint 0 stall request ends transaction with STALL, then clears itself.
// - Premature end sets flag, flushes endpoint 0 FIFO, requests interrupt.
// - Firmware sets data-end at last packet or zero-length; device clears it.
// - Endpoint 0 stall-sent set after STALL with interrupt; firmware clears.
// - Endpoint 0 tx-ready set by firmware; cleared with interrupt once sent.
// - Toggle reset forces next IN packet to DATA0; bit clears itself.
// - IN stall sent sets flag, flushes FIFO, drops ready, requests interrupt.
// - IN stall request answers tokens with STALL; ignored when isochronous.
// - Flush write drops one packet and tx-ready; two writes empty two.
// - Isochronous token without ready packet sends zero-length, flags underrun.
// - Bulk/interrupt NAK reply flags underrun; firmware clears it.
// - Occupied bit reads one while any packet sits in IN FIFO.
// - IN tx-ready set by firmware; cleared with interrupt once sent.
// - Per-endpoint interrupt enables, one enables, all reset to one.
// - IN type bit: zero bulk/interrupt, one isochronous.

`timescale 1ns/1ps

module uep_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [uep_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [uep_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Endpoint 0 engine events
  input wire logic ep0_rx_packet,
  input wire logic ep0_premature_end,
  input wire logic ep0_stall_done,
  input wire logic ep0_tx_done,
  input wire logic ep0_phase_done,
  // Endpoint 0 engine controls
  output logic ep0_stall_request,
  output logic ep0_tx_packet_ready,
  output logic ep0_data_end,
  output logic ep0_fifo_flush,
  // IN endpoint engine events
  input wire logic in_token,
  input wire logic [2:0] in_token_ep,
  input wire logic in_sent,
  input wire logic [2:0] in_sent_ep,
  input wire logic fifo_load,
  input wire logic [2:0] fifo_load_ep,
  // IN endpoint engine controls
  output logic in_reply_valid,
  output logic [1:0] in_reply,
  output logic in_reply_toggle,
  output logic [4:0] in_flush,
  // Interrupt requests, bit 0 endpoint 0
  output logic [5:0] irq_request
);
  localparam int N = uep_pkg::NUM_IN_EP;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0] endpoint_select_index;
  logic [5:0] irq_enable;
  logic [N-1:0] iso_sel;
  logic premature, rx_ready, ep0_stall_sent;
  logic aw_full, w_full;
  logic [15:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane;

  // Decoded strobes and per-endpoint results
  logic wr_go, csr_wr, ep0_wr;
  logic [N-1:0] in_wr, tok, snt, ld, ev_in, fl_in, tog_in;
  logic [N-1:0][7:0] in_status;
  logic [N-1:0][1:0] rep_in;
  logic [7:0] ep0_status;
  logic [31:0] rd_word;
  logic rd_hit, wr_hit;
  logic [2:0] tok_sel;

  // Write fires once both halves are held and no response waits
  assign wr_go = aw_full && w_full && !bvalid;
  assign csr_wr = wr_go && wr_lane && wr_idx == uep_pkg::IDX_CSR;
  assign ep0_wr = csr_wr && endpoint_select_index == 4'h0;
  assign wr_hit = wr_idx == uep_pkg::IDX_CSR || wr_idx == uep_pkg::IDX_SELECT
    || wr_idx == uep_pkg::IDX_IRQ_ENABLE || wr_idx == uep_pkg::IDX_IN_TYPE;
  assign tok_sel = in_token_ep - 3'h1;

  // Per-endpoint strobes from engine and firmware
  always_comb begin
    for (int i = 0; i < N; i++) begin
      in_wr[i] = csr_wr && endpoint_select_index == 4'(i + 1);
      tok[i] = in_token && in_token_ep == 3'(i + 1);
      snt[i] = in_sent && in_sent_ep == 3'(i + 1);
      ld[i] = fifo_load && fifo_load_ep == 3'(i + 1);
    end
  end

  // ----------------------------------------------------------------
  // IN endpoints, one private state each
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_in
    uep_in_ep u_ep (
      .aclk(aclk),
      .aresetn(aresetn),
      .csr_wr(in_wr[g]),
      .wdata(wr_byte),
      .iso(iso_sel[g]),
      .token(tok[g]),
      .sent(snt[g]),
      .load(ld[g]),
      .status(in_status[g]),
      .reply(rep_in[g]),
      .toggle(tog_in[g]),
      .irq_event(ev_in[g]),
      .flush_pulse(fl_in[g])
    );
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are held separately so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      awready <= 1'b0;
      wr_idx <= 16'h0000;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      awready <= 1'b0;
      wr_idx <= awaddr[17:2];
    end else if (wr_go) begin
      aw_full <= 1'b0;
    end else if (!aw_full && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      wready <= 1'b0;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
    end else if (wvalid && wready) begin
      w_full <= 1'b1;
      wready <= 1'b0;
      wr_byte <= wdata[7:0];
      wr_lane <= wstrb[0];
    end else if (wr_go) begin
      w_full <= 1'b0;
    end else if (!w_full && !bvalid) begin
      wready <= 1'b1;
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= uep_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? uep_pkg::RESP_OKAY : uep_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Plain configuration registers
  // ----------------------------------------------------------------
  // Index keeps four bits; values above five select nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      endpoint_select_index <= uep_pkg::INDEX_RESET;
      irq_enable <= uep_pkg::IRQ_ENABLE_RESET;
      iso_sel <= '0;
    end else if (wr_go && wr_lane) begin
      if (wr_idx == uep_pkg::IDX_SELECT) begin
        endpoint_select_index <= wr_byte[3:0];
      end
      if (wr_idx == uep_pkg::IDX_IRQ_ENABLE) begin
        irq_enable <= wr_byte[5:0];
      end
      if (wr_idx == uep_pkg::IDX_IN_TYPE && endpoint_select_index != 4'h0
          && endpoint_select_index <= uep_pkg::INDEX_MAX) begin
        iso_sel[3'(endpoint_select_index - 4'h1)] <= wr_byte[uep_pkg::TYPE_ISO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 0 control/status
  // ----------------------------------------------------------------
  // Hardware events win over a same-cycle firmware clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      premature <= 1'b0;
      rx_ready <= 1'b0;
      ep0_stall_sent <= 1'b0;
    end else begin
      if (ep0_premature_end) begin
        premature <= 1'b1;
      end else if (ep0_wr && wr_byte[uep_pkg::CS0_CLR_PREMATURE]) begin
        premature <= 1'b0;
      end
      if (ep0_rx_packet) begin
        rx_ready <= 1'b1;
      end else if (ep0_wr && wr_byte[uep_pkg::CS0_CLR_RX]) begin
        rx_ready <= 1'b0;
      end
      if (ep0_stall_done) begin
        ep0_stall_sent <= 1'b1;
      end else if (ep0_wr) begin
        ep0_stall_sent <= ep0_stall_sent & wr_byte[uep_pkg::CS0_STALL_SENT];
      end
    end
  end

  // Firmware-set handshake bits, cleared by the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep0_stall_request <= 1'b0;
      ep0_tx_packet_ready <= 1'b0;
      ep0_data_end <= 1'b0;
    end else begin
      if (ep0_wr && wr_byte[uep_pkg::CS0_STALL_REQ]) begin
        ep0_stall_request <= 1'b1;
      end else if (ep0_stall_done) begin
        ep0_stall_request <= 1'b0;
      end
      if (ep0_wr && wr_byte[uep_pkg::CS0_TX_READY]) begin
        ep0_tx_packet_ready <= 1'b1;
      end else if (ep0_tx_done) begin
        ep0_tx_packet_ready <= 1'b0;
      end
      if (ep0_wr && wr_byte[uep_pkg::CS0_DATA_END]) begin
        ep0_data_end <= 1'b1;
      end else if (ep0_phase_done) begin
        ep0_data_end <= 1'b0;
      end
    end
  end

  // Clear bits are never stored, so they read zero
  assign ep0_status = {2'b00, ep0_stall_request, premature, ep0_data_end,
    ep0_stall_sent, ep0_tx_packet_ready, rx_ready};

  // ----------------------------------------------------------------
  // Engine-facing registered outputs
  // ----------------------------------------------------------------
  // Interrupt pulses gated by enables; flushes registered per endpoint
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 6'h00;
      ep0_fifo_flush <= 1'b0;
      in_flush <= 5'h00;
    end else begin
      irq_request <= {ev_in, ep0_rx_packet | ep0_premature_end | ep0_stall_done
        | ep0_tx_done} & irq_enable;
      ep0_fifo_flush <= ep0_premature_end;
      in_flush <= fl_in;
    end
  end

  // Token answer one cycle after the token; unknown endpoints get none
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_reply_valid <= 1'b0;
      in_reply <= uep_pkg::REPLY_NAK;
      in_reply_toggle <= 1'b0;
    end else begin
      in_reply_valid <= in_token && in_token_ep != 3'h0 && in_token_ep <= 3'h5;
      if (in_token && in_token_ep != 3'h0 && in_token_ep <= 3'h5) begin
        in_reply <= rep_in[tok_sel];
        in_reply_toggle <= tog_in[tok_sel];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Shared address steered by the index; out-of-range index reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (araddr[17:2])
      uep_pkg::IDX_CSR: begin
        if (endpoint_select_index == 4'h0) begin
          rd_word[7:0] = ep0_status;
        end else if (endpoint_select_index <= uep_pkg::INDEX_MAX) begin
          rd_word[7:0] = in_status[3'(endpoint_select_index - 4'h1)];
        end
      end
      uep_pkg::IDX_SELECT: rd_word[3:0] = endpoint_select_index;
      uep_pkg::IDX_IRQ_ENABLE: rd_word[5:0] = irq_enable;
      uep_pkg::IDX_IN_TYPE: begin
        if (endpoint_select_index != 4'h0 && endpoint_select_index <= uep_pkg::INDEX_MAX) begin
          rd_word[uep_pkg::TYPE_ISO] = iso_sel[3'(endpoint_select_index - 4'h1)];
        end
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Data registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= uep_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? uep_pkg::RESP_OKAY : uep_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_EP0_VIEW: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && araddr[17:2] == uep_pkg::IDX_CSR && endpoint_select_index == 4'h0
    |=> rdata[7:0] == $past(ep0_status))
    else $error("wrong view at index zero");
  AST_PREMATURE_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    ep0_wr && wr_byte[uep_pkg::CS0_CLR_PREMATURE] && !ep0_premature_end |=> !premature)
    else $error("premature flag not cleared");
  AST_RX_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    ep0_rx_packet && irq_enable[0] |=> rx_ready && irq_request[0])
    else $error("rx ready without interrupt");
  AST_STALL_SELF_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    ep0_stall_done && !(ep0_wr && wr_byte[uep_pkg::CS0_STALL_REQ])
    |=> !ep0_stall_request && ep0_stall_sent)
    else $error("stall request stayed set");
  AST_PREMATURE_FLUSH: assert property (@(posedge aclk) disable iff (!aresetn)
    ep0_premature_end |=> premature && ep0_fifo_flush
    ##1 (!ep0_fifo_flush || $past(ep0_premature_end)))
    else $error("premature end not flushed");
  AST_IRQ_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    !irq_enable[0] |=> !irq_request[0])
    else $error("masked interrupt raised");
  AST_WRITE_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> bvalid && !awready && !wready)
    else $error("write response late");
  COV_EP0_STALL: cover property (@(posedge aclk) disable iff (!aresetn)
    ep0_stall_request ##[1:20] ep0_stall_done);
  COV_DATA_END: cover property (@(posedge aclk) disable iff (!aresetn)
    ep0_data_end ##1 ep0_phase_done);
  COV_IN_STALL: cover property (@(posedge aclk) disable iff (!aresetn)
    in_reply_valid && in_reply == uep_pkg::REPLY_STALL);
endmodule // uep_ctrl

// File: test/uep_engine_model.sv
// Purpose: USB engine stand-in that raises event pulses for the control block
// Assumes: Bench asks for one event per go strobe
// Notes: Endpoint lines churn while idle so a stale value never passes
`timescale 1ns/1ps
module uep_engine_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Commands from the bench
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [2:0] ep,
  // Event pulses toward the block
  output logic [7:0] ev,
  output logic [2:0] ev_ep
);
  // One-cycle pulse per command, on the bit picked by kind
  always_ff @(posedge aclk) begin
    ev <= (go && aresetn) ? (8'h01 << kind) : 8'h00;
    ev_ep <= !aresetn ? 3'h0 : (go ? ep : ~ev_ep);
  end
endmodule // uep_engine_model

// File: test/test_uep_ctrl.sv
// Purpose: Self-checking bench for the endpoint control block
// Assumes: Engine model raises all event pulses
// Notes: Registers reached by AXI4-Lite word tasks
`timescale 1ns/1ps
module test_uep_ctrl;
  localparam logic [15:0] CSR = uep_pkg::IDX_CSR;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
  logic awready, wready, bvalid, arready, rvalid, in_reply_valid, in_reply_toggle;
  logic ep0_stall_request, ep0_tx_packet_ready, ep0_data_end, ep0_fifo_flush;
  logic [uep_pkg::ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, in_reply;
  logic [3:0] wstrb;
  logic [4:0] in_flush;
  logic [5:0] irq_request;
  logic [7:0] ev;
  logic [2:0] kind, ep, ev_ep;
  int errors, compares;
  logic [33:0] pulses, ep0_lv, rep_lv;
  uep_ctrl dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .ep0_rx_packet(ev[0]), .ep0_premature_end(ev[1]),
    .ep0_stall_done(ev[2]), .ep0_tx_done(ev[3]), .ep0_phase_done(ev[4]),
    .ep0_stall_request, .ep0_tx_packet_ready, .ep0_data_end, .ep0_fifo_flush,
    .in_token(ev[5]), .in_token_ep(ev_ep), .in_sent(ev[6]), .in_sent_ep(ev_ep),
    .fifo_load(ev[7]), .fifo_load_ep(ev_ep), .in_reply_valid, .in_reply,
    .in_reply_toggle, .in_flush, .irq_request);
  uep_engine_model eng (.aclk, .aresetn, .go, .kind, .ep, .ev, .ev_ep);
  assign ep0_lv = {31'h0, ep0_stall_request, ep0_tx_packet_ready, ep0_data_end};
  assign rep_lv = {31'h0, in_reply_toggle, in_reply};
  // Sticky record of one-cycle outputs since the last engine command
  always @(posedge aclk) begin
    if (go) begin
      pulses <= '0;
    end else begin
      pulses <= pulses | {21'h0, in_reply_valid, in_flush, ep0_fifo_flush, irq_request};
    end
  end
  // Free-running system clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write; address and data released as each is taken
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bit aw_open, w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each half is released at the edge where its own ready is seen
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && awready) begin
        awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && wready) begin
        wvalid <= 1'b0;
        w_open = 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    chk({32'h0, bresp}, {32'h0, uep_pkg::RESP_OKAY});
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    chk({rresp, rdata}, {er, 24'h0, e});
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // One engine event, then time for the block to answer
  task automatic event_pulse(input logic [2:0] k, input logic [2:0] e);
    go <= 1'b1;
    kind <= k;
    ep <= e;
    @(posedge aclk);
    go <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic stop_test;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge aclk);
    errors++;
    stop_test;
  end
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, go} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    kind = '0;
    ep = '0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(uep_pkg::IDX_IRQ_ENABLE, 8'h3f, 2'h0);
    rd_chk(CSR, 8'h00, 2'h0);
    event_pulse(3'h0, 3'h0);
    chk(pulses, 34'h1);
    rd_chk(CSR, 8'h01, 2'h0);
    wr(CSR, 8'h40);
    rd_chk(CSR, 8'h00, 2'h0);
    event_pulse(3'h1, 3'h0);
    chk(pulses, 34'h41);
    rd_chk(CSR, 8'h10, 2'h0);
    wr(CSR, 8'h80);
    rd_chk(CSR, 8'h00, 2'h0);
    wr(CSR, 8'h20);
    chk(ep0_lv, 34'h4);
    event_pulse(3'h2, 3'h0);
    chk(pulses, 34'h1);
    rd_chk(CSR, 8'h04, 2'h0);
    wr(CSR, 8'h0a);
    chk(ep0_lv, 34'h3);
    rd_chk(CSR, 8'h0a, 2'h0);
    event_pulse(3'h3, 3'h0);
    chk(pulses, 34'h1);
    event_pulse(3'h4, 3'h0);
    chk(ep0_lv, 34'h0);
    wr(uep_pkg::IDX_IRQ_ENABLE, 8'h3e);
    event_pulse(3'h0, 3'h0);
    chk(pulses, 34'h0);
    wr(uep_pkg::IDX_SELECT, 8'h01);
    wr(CSR, 8'h10);
    event_pulse(3'h5, 3'h1);
    chk(rep_lv, {32'h0, uep_pkg::REPLY_STALL});
    chk(pulses, 34'h1082);
    rd_chk(CSR, 8'h30, 2'h0);
    wr(CSR, 8'h00);
    event_pulse(3'h5, 3'h1);
    chk(rep_lv, {32'h0, uep_pkg::REPLY_NAK});
    chk(pulses, 34'h1000);
    rd_chk(CSR, 8'h04, 2'h0);
    event_pulse(3'h7, 3'h1);
    event_pulse(3'h7, 3'h1);
    wr(CSR, 8'h01);
    rd_chk(CSR, 8'h03, 2'h0);
    wr(CSR, 8'h08);
    rd_chk(CSR, 8'h02, 2'h0);
    chk(pulses, 34'h80);
    wr(uep_pkg::IDX_IN_TYPE, 8'h40);
    event_pulse(3'h5, 3'h1);
    chk(rep_lv, {32'h0, uep_pkg::REPLY_ZLP});
    rd_chk(CSR, 8'h06, 2'h0);
    wr(CSR, 8'h01);
    event_pulse(3'h5, 3'h1);
    chk(rep_lv, {32'h0, uep_pkg::REPLY_DATA});
    event_pulse(3'h6, 3'h1);
    chk(pulses, 34'h2);
    rd_chk(CSR, 8'h00, 2'h0);
    event_pulse(3'h5, 3'h1);
    chk(rep_lv, {31'h0, 1'b1, uep_pkg::REPLY_ZLP});
    wr(CSR, 8'h40);
    event_pulse(3'h5, 3'h1);
    chk(rep_lv, {32'h0, uep_pkg::REPLY_ZLP});
    rd_chk(16'h0000, 8'h00, uep_pkg::RESP_SLVERR);
    stop_test;
  end
endmodule // test_uep_ctrl
